//--- inc/prio_irq_pkg.sv
// Purpose: shared constants and types for the prioritised interrupt block
// Assumes: AXI4-Lite register access, 32-bit data, 25 MHz clock
// Notes:   offsets are byte addresses of aligned words
package prio_irq_pkg;

  // ----------------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------------
  localparam int NUM_SRC   = 16;
  localparam int IDX_W     = 4;
  localparam int PRIO_W    = 8;
  localparam int PRIO_BITS = 3;
  localparam int ADDR_W    = 8;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFF_ENABLE    = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_PEND_SET  = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_PEND_CLR  = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_THRESHOLD = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_GROUPING  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_VTBASE    = 8'h14;
  localparam logic [ADDR_W-1:0] OFF_GATE      = 8'h18;
  localparam logic [ADDR_W-1:0] OFF_ACTIVE    = 8'h1c;
  localparam logic [ADDR_W-1:0] OFF_EVT_STAT  = 8'h20;
  localparam logic [ADDR_W-1:0] OFF_EVT_MASK  = 8'h24;
  localparam logic [ADDR_W-1:0] OFF_PRIO_BASE = 8'h40;

  // ----------------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------------
  localparam int VT_ALIGN_LSB = 10;
  localparam logic [31:0] VTBASE_RST   = 32'h0000_0000;
  localparam logic [7:0]  THRESH_RST   = 8'h00;
  localparam logic [2:0]  GROUP_RST    = 3'h0;
  localparam logic [1:0]  AXI_OKAY     = 2'b00;
  localparam logic [1:0]  AXI_SLVERR   = 2'b10;
  localparam int EVT_W      = 2;
  localparam int EVT_TAKEN  = 0;
  localparam int EVT_DROP   = 1;

  typedef struct packed {
    logic              valid;
    logic [IDX_W-1:0]  index;
    logic [PRIO_BITS-1:0] level;
  } winner_s;

endpackage : prio_irq_pkg

//--- logic/prio_pick.sv
// Purpose: finds the most urgent eligible source
// Assumes: smaller level is more urgent, ties go to lower index
// Notes:   purely combinational linear scan of compares
`timescale 1ns/1ps
`default_nettype none
module prio_pick (
  input  wire logic [prio_irq_pkg::NUM_SRC-1:0]   eligible_in,
  input  wire logic [prio_irq_pkg::NUM_SRC*prio_irq_pkg::PRIO_BITS-1:0]
                                                   levels_in,
  output var  prio_irq_pkg::winner_s               winner_out
);

  // ----------------------------------------------------------------------
  // linear scan, strict less-than keeps lower index on a tie
  // ----------------------------------------------------------------------
  always_comb begin
    winner_out = '0;
    for (int i = 0; i < prio_irq_pkg::NUM_SRC; i++) begin
      if (eligible_in[i] && (!winner_out.valid ||
          levels_in[i*prio_irq_pkg::PRIO_BITS +: prio_irq_pkg::PRIO_BITS]
          < winner_out.level)) begin
        winner_out.valid = 1'b1;
        winner_out.index = prio_irq_pkg::IDX_W'(i);
        winner_out.level =
          levels_in[i*prio_irq_pkg::PRIO_BITS +: prio_irq_pkg::PRIO_BITS];
      end
    end
  end

endmodule : prio_pick
`default_nettype wire

//--- logic/nested_priority_interrupt_ctrl.sv
// Purpose: prioritised vectored interrupt controller with AXI4-Lite regs
// Assumes: single clock, sources are asynchronous levels
// Notes:   core takes an entry with ack, returns with done
//
// Implementation choices: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module nested_priority_interrupt_ctrl (
  input  wire logic                              ref_clk_in,
  input  wire logic                              rst_n_in,
  input  wire logic [prio_irq_pkg::NUM_SRC-1:0]  irq_src_in,
  input  wire logic                              entry_ack_in,
  input  wire logic                              handler_done_in,
  output logic                                   cpu_irq_out,
  output logic [31:0]                            handler_pointer_out,
  output logic [prio_irq_pkg::IDX_W-1:0]         source_index_out,
  output logic                                   evt_irq_out,
  input  wire logic [prio_irq_pkg::ADDR_W-1:0]   s_axi_awaddr,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  output logic [1:0]                             s_axi_bresp,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  input  wire logic [prio_irq_pkg::ADDR_W-1:0]   s_axi_araddr,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  output logic [31:0]                            s_axi_rdata,
  output logic [1:0]                             s_axi_rresp,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready
);

  localparam int N  = prio_irq_pkg::NUM_SRC;
  localparam int PB = prio_irq_pkg::PRIO_BITS;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OFFER = 2'b10
  } dispatch_e;

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [N-1:0]        sync1_r, sync2_r, src_prev_r;
  logic [N-1:0]        enable_r, pending_r;
  logic [7:0]          prio_r [N];
  logic [7:0]          threshold_r;
  logic [2:0]          grouping_r;
  logic [31:0]         vtbase_r;
  logic                gate_r;
  logic [PB:0]         active_lvl_r;   // msb set means none running
  logic [PB:0]         stack_r [N];    // saved levels of preempted handlers
  logic [prio_irq_pkg::IDX_W:0] depth_r;
  dispatch_e           state_r;
  logic [prio_irq_pkg::EVT_W-1:0] evt_stat_r, evt_mask_r;
  logic                aw_got_r, w_got_r;
  logic [prio_irq_pkg::ADDR_W-1:0] aw_addr_r;
  logic [31:0]         w_data_r;
  logic [3:0]          w_strb_r;

  // ----------------------------------------------------------------------
  // priority selection
  // ----------------------------------------------------------------------
  logic [N*PB-1:0]     levels;
  logic [N-1:0]        eligible;
  prio_irq_pkg::winner_s winner;
  logic [PB-1:0]       thr_lvl;
  logic                preempt_ok;

  assign thr_lvl = threshold_r[7 -: PB];

  // per source level and eligibility
  genvar g;
  generate
    for (g = 0; g < N; g++) begin : g_src
      assign levels[g*PB +: PB] = prio_r[g][7 -: PB];
      assign eligible[g] = pending_r[g] && enable_r[g]
        && (threshold_r == 8'h00
            || prio_r[g][7 -: PB] < thr_lvl);
    end
  endgenerate

  prio_pick u_pick (
    .eligible_in (eligible),
    .levels_in   (levels),
    .winner_out  (winner)
  );

  // all three implemented bits preempt for any grouping value
  // grouping 0..7 therefore collapses to the same compare
  assign preempt_ok = winner.valid &&
    ({1'b0, winner.level} < active_lvl_r);

  // ----------------------------------------------------------------------
  // source sync and edge capture
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r    <= '0;
      sync2_r    <= '0;
      src_prev_r <= '0;
    end else begin
      sync1_r    <= irq_src_in;
      sync2_r    <= sync1_r;
      src_prev_r <= sync2_r;
    end
  end

  // ----------------------------------------------------------------------
  // register write decode
  // ----------------------------------------------------------------------
  logic wr_fire, rd_fire;
  logic [31:0] wmask;
  assign wr_fire = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wmask = {{8{w_strb_r[3]}}, {8{w_strb_r[2]}},
                  {8{w_strb_r[1]}}, {8{w_strb_r[0]}}};

  logic wr_en, wr_pset, wr_pclr, wr_prio_hit;
  logic [prio_irq_pkg::IDX_W-1:0] wr_prio_idx;
  assign wr_en   = wr_fire && aw_addr_r == prio_irq_pkg::OFF_ENABLE;
  assign wr_pset = wr_fire && aw_addr_r == prio_irq_pkg::OFF_PEND_SET;
  assign wr_pclr = wr_fire && aw_addr_r == prio_irq_pkg::OFF_PEND_CLR;
  assign wr_prio_hit = wr_fire &&
    aw_addr_r[7:6] == prio_irq_pkg::OFF_PRIO_BASE[7:6];
  assign wr_prio_idx = aw_addr_r[2 +: prio_irq_pkg::IDX_W];

  logic take;
  assign take = (state_r == ST_OFFER) && entry_ack_in;

  // ----------------------------------------------------------------------
  // pending: edge or set makes pending, clear or entry drops it
  // ----------------------------------------------------------------------
  logic [N-1:0] take_vec, pend_set;
  assign take_vec = take ? (N'(1) << source_index_out) : '0;
  assign pend_set = (sync2_r & ~src_prev_r)
                  | (wr_pset ? w_data_r[N-1:0] : '0);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pending_r <= '0;
    end else begin
      pending_r <= (pending_r
                   & ~(wr_pclr ? w_data_r[N-1:0] : '0)
                   & ~take_vec) | pend_set;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      enable_r    <= '0;
      threshold_r <= prio_irq_pkg::THRESH_RST;
      grouping_r  <= prio_irq_pkg::GROUP_RST;
      vtbase_r    <= prio_irq_pkg::VTBASE_RST;
      gate_r      <= 1'b0;
      evt_mask_r  <= '0;
      for (int i = 0; i < N; i++) prio_r[i] <= 8'h00;
    end else if (wr_fire) begin
      case (aw_addr_r)
        prio_irq_pkg::OFF_ENABLE:
          enable_r <= (enable_r & ~wmask[N-1:0])
                      | (w_data_r[N-1:0] & wmask[N-1:0]);
        prio_irq_pkg::OFF_THRESHOLD:
          if (w_strb_r[0]) threshold_r <= w_data_r[7:0];
        prio_irq_pkg::OFF_GROUPING:
          if (w_strb_r[0]) grouping_r <= w_data_r[2:0];
        prio_irq_pkg::OFF_VTBASE:   // low bits dropped
          vtbase_r <= ((vtbase_r & ~wmask) | (w_data_r & wmask))
                      & ~32'h0000_03ff;
        prio_irq_pkg::OFF_GATE:
          if (w_strb_r[0]) gate_r <= w_data_r[0];
        prio_irq_pkg::OFF_EVT_MASK:
          if (w_strb_r[0]) evt_mask_r <= w_data_r[prio_irq_pkg::EVT_W-1:0];
        default: begin
          if (wr_prio_hit && w_strb_r[0]) prio_r[wr_prio_idx] <= w_data_r[7:0];
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // dispatch: offer winner, nest on ack, unwind on done
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_r             <= ST_IDLE;
      cpu_irq_out         <= 1'b0;
      handler_pointer_out <= 32'h0000_0000;
      source_index_out    <= '0;
      active_lvl_r        <= {1'b1, {PB{1'b0}}};
      depth_r             <= '0;
      for (int i = 0; i < N; i++) stack_r[i] <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          cpu_irq_out <= 1'b0;
          if (handler_done_in && depth_r != '0) begin
            active_lvl_r <= stack_r[depth_r[prio_irq_pkg::IDX_W-1:0] - 1'b1];
            depth_r      <= depth_r - 1'b1;
          end else if (preempt_ok && gate_r) begin
            state_r             <= ST_OFFER;
            cpu_irq_out         <= 1'b1;
            source_index_out    <= winner.index;
            handler_pointer_out <= vtbase_r +
              {26'h0, winner.index, 2'b00};
          end
        end
        ST_OFFER: begin
          if (take) begin
            state_r      <= ST_IDLE;
            cpu_irq_out  <= 1'b0;
            stack_r[depth_r[prio_irq_pkg::IDX_W-1:0]] <= active_lvl_r;
            depth_r      <= depth_r + 1'b1;
            active_lvl_r <= {1'b0, prio_r[source_index_out][7 -: PB]};
          end else if (!preempt_ok || !gate_r) begin
            state_r     <= ST_IDLE;   // withdrawn: cleared, disabled, gated
            cpu_irq_out <= 1'b0;
          end else begin
            source_index_out    <= winner.index;   // offer follows the current winner
            handler_pointer_out <= vtbase_r + {26'h0, winner.index, 2'b00};
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // event status: taken entry, discarded pending
  // ----------------------------------------------------------------------
  logic [prio_irq_pkg::EVT_W-1:0] evt_set;
  assign evt_set[prio_irq_pkg::EVT_TAKEN] = take;
  assign evt_set[prio_irq_pkg::EVT_DROP]  =
    wr_pclr && |(pending_r & w_data_r[N-1:0]);

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      evt_stat_r  <= '0;
      evt_irq_out <= 1'b0;
    end else begin
      evt_stat_r <= (evt_stat_r &
        ~((wr_fire && aw_addr_r == prio_irq_pkg::OFF_EVT_STAT && w_strb_r[0])
          ? w_data_r[prio_irq_pkg::EVT_W-1:0] : '0)) | evt_set;
      evt_irq_out <= |(evt_stat_r & evt_mask_r);
    end
  end

  // ----------------------------------------------------------------------
  // axi write channels, either order, response after both
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= '0;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= prio_irq_pkg::AXI_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_got_r      <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_got_r      <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r[1:0] == 2'b00 && (wr_prio_hit ? 
          5'(aw_addr_r[5:2]) < 5'(N)
          : (aw_addr_r <= prio_irq_pkg::OFF_EVT_MASK
          && aw_addr_r != prio_irq_pkg::OFF_ACTIVE)))
          ? prio_irq_pkg::AXI_OKAY : prio_irq_pkg::AXI_SLVERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        aw_got_r      <= 1'b0;
        w_got_r       <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // axi read channel
  // ----------------------------------------------------------------------
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= prio_irq_pkg::AXI_OKAY;
    end else if (rd_fire) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rresp   <= prio_irq_pkg::AXI_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
      case (s_axi_araddr)
        prio_irq_pkg::OFF_ENABLE:    s_axi_rdata <= 32'(enable_r);
        prio_irq_pkg::OFF_PEND_SET,
        prio_irq_pkg::OFF_PEND_CLR:  s_axi_rdata <= 32'(pending_r);
        prio_irq_pkg::OFF_THRESHOLD: s_axi_rdata <= 32'(threshold_r);
        prio_irq_pkg::OFF_GROUPING:  s_axi_rdata <= 32'(grouping_r);
        prio_irq_pkg::OFF_VTBASE:    s_axi_rdata <= vtbase_r;
        prio_irq_pkg::OFF_GATE:      s_axi_rdata <= 32'(gate_r);
        prio_irq_pkg::OFF_ACTIVE:    s_axi_rdata <= 32'(active_lvl_r);
        prio_irq_pkg::OFF_EVT_STAT:  s_axi_rdata <= 32'(evt_stat_r);
        prio_irq_pkg::OFF_EVT_MASK:  s_axi_rdata <= 32'(evt_mask_r);
        default: begin
          if (s_axi_araddr[7:6] == prio_irq_pkg::OFF_PRIO_BASE[7:6]
              && s_axi_araddr[1:0] == 2'b00 && 5'(s_axi_araddr[5:2]) < 5'(N))
            s_axi_rdata <= 32'(prio_r[s_axi_araddr[5:2]]);
          else
            s_axi_rresp <= prio_irq_pkg::AXI_SLVERR;
        end
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : nested_priority_interrupt_ctrl
`default_nettype wire

//--- dv/prio_irq_chk.sv
// Purpose: port checker for the prioritised interrupt controller
// Assumes: one clock domain, asynchronous active-low reset
// Notes:   bound to every instance of the controller
`timescale 1ns/1ps
`default_nettype none
module prio_irq_chk (
  input  wire logic                            ref_clk_in,
  input  wire logic                            rst_n_in,
  input  wire logic                            entry_ack_in,
  input  wire logic                            cpu_irq_out,
  input  wire logic [31:0]                     handler_pointer_out,
  input  wire logic [prio_irq_pkg::IDX_W-1:0]  source_index_out,
  input  wire logic                            s_axi_awvalid,
  input  wire logic                            s_axi_awready,
  input  wire logic                            s_axi_wvalid,
  input  wire logic                            s_axi_wready,
  input  wire logic                            s_axi_bvalid,
  input  wire logic                            s_axi_bready,
  input  wire logic [1:0]                      s_axi_bresp,
  input  wire logic                            s_axi_arvalid,
  input  wire logic                            s_axi_arready,
  input  wire logic                            s_axi_rvalid,
  input  wire logic                            s_axi_rready,
  input  wire logic [31:0]                     s_axi_rdata
);
  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // ----------------------------------------------------------------
  // core link and bus handshakes
  // ----------------------------------------------------------------
  property p_ack; entry_ack_in && cpu_irq_out |=> !cpu_irq_out; endproperty
  a_ack: assert property (p_ack) else $error("offer kept after ack");
  property p_ptr;
    cpu_irq_out |-> handler_pointer_out[9:0] == {4'h0, source_index_out, 2'b00};
  endproperty
  a_ptr: assert property (p_ptr) else $error("vector address wrong");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("write answer lost");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("read answer lost");
  property p_wr;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid;
  endproperty
  a_wr: assert property (p_wr) else $error("write answer late");
  property p_rd; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 s_axi_rvalid || !s_axi_rready; endproperty
  a_rd: assert property (p_rd) else $error("read answer late");
  property p_rone; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rone: assert property (p_rone) else $error("second read taken");
  property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid ##0 s_axi_awready && s_axi_wready; endproperty
  a_bdone: assert property (p_bdone) else $error("write not closed");
endmodule : prio_irq_chk
bind nested_priority_interrupt_ctrl prio_irq_chk u_chk (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .entry_ack_in(entry_ack_in),
  .cpu_irq_out(cpu_irq_out), .handler_pointer_out(handler_pointer_out),
  .source_index_out(source_index_out), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .s_axi_rdata(s_axi_rdata));
`default_nettype wire

//--- dv/core_model.sv
// Purpose: processor core that takes vectored interrupts
// Assumes: takes every offer at once, returns when told
// Notes:   counts entries and keeps the last vector seen
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        cpu_irq_in,
  input  wire logic [31:0] pointer_in,
  input  wire logic [3:0]  index_in,
  output logic             ack_out,
  output logic             done_out
);
  int          taken;
  logic [31:0] last_ptr;
  logic [3:0]  last_idx;
  initial done_out = 1'b0;
  // one-cycle ack per offer, vector captured on the take
  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ack_out <= 1'b0;
      taken   <= 0;
    end else begin
      ack_out <= cpu_irq_in && !ack_out;
      if (ack_out && cpu_irq_in) begin
        taken    <= taken + 1;
        last_ptr <= pointer_in;
        last_idx <= index_in;
      end
    end
  end
  // return from the innermost handler while nothing is offered
  task automatic finish();
    @(posedge ref_clk_in);
    while (cpu_irq_in) @(posedge ref_clk_in);
    done_out <= 1'b1;
    @(posedge ref_clk_in);
    done_out <= 1'b0;
  endtask : finish
endmodule : core_model
`default_nettype wire

//--- dv/tb.sv
// Purpose: self-checking bench for the interrupt controller
// Assumes: core model acks every offer
// Notes:   registers reached over the bus tasks only
`timescale 1ns/1ps
`default_nettype none
`define PK prio_irq_pkg::
`define CHK(nm,e,g) begin checked++; if ((g) !== (e)) begin errors++; \
  $display("[ERR] %s exp %h got %h", nm, e, g); end end
module tb;
  logic        clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, awready, wready, bvalid, arready;
  logic        rvalid, irq, ack, done, evt;
  logic [15:0] src = '0;
  logic [7:0]  awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, ptr, vtb = '0;
  logic [3:0]  wstrb = '0, idx;
  logic [1:0]  bresp, rresp;
  int          errors = 0, checked = 0, seen = 0, cyc = 0;
  always #20 clk = ~clk;
  nested_priority_interrupt_ctrl u_dut (.ref_clk_in(clk), .rst_n_in(rst_n),
    .irq_src_in(src), .entry_ack_in(ack), .handler_done_in(done),
    .cpu_irq_out(irq), .handler_pointer_out(ptr), .source_index_out(idx),
    .evt_irq_out(evt), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  core_model u_core (.ref_clk_in(clk), .rst_n_in(rst_n), .cpu_irq_in(irq),
    .pointer_in(ptr), .index_in(idx), .ack_out(ack), .done_out(done));
  // ----------------------------------------------------------------
  // bus and core helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    input logic [1:0] er = `PK AXI_OKAY);
    @(posedge clk);
    awaddr  <= a;
    wdata   <= d;
    wstrb   <= 4'hf;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    do begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (!(bvalid && bready));
    bready <= 1'b0;
    `CHK("bresp", er, bresp)
  endtask : wr
  task automatic rd(input string nm, input logic [7:0] a,
                    input logic [31:0] e, input logic [1:0] er = `PK AXI_OKAY);
    @(posedge clk);
    araddr  <= a;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    do begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (!(rvalid && rready));
    rready <= 1'b0;
    `CHK(nm, e, rdata)
    `CHK("rresp", er, rresp)
  endtask : rd
  task automatic setp(input int i, input logic [7:0] v);
    wr(`PK OFF_PRIO_BASE + 8'(4 * i), {24'h0, v});
  endtask : setp
  task automatic took(input logic [3:0] i);
    int n = 0;
    while (u_core.taken == seen && n < 40) begin
      @(posedge clk);
      n++;
    end
    seen++;
    `CHK("took", 1'b1, n < 40)
    `CHK("index", i, u_core.last_idx)
    `CHK("pointer", vtb + {i, 2'b00}, u_core.last_ptr)
  endtask : took
  task automatic quiet(input int c);
    repeat (c) @(posedge clk);
    `CHK("no entry", seen, u_core.taken)
  endtask : quiet
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs();
    rd("thresh rst", `PK OFF_THRESHOLD, 32'h0);
    rd("active rst", `PK OFF_ACTIVE, 32'h8);
    wr(`PK OFF_THRESHOLD, 32'ha0);
    rd("thresh", `PK OFF_THRESHOLD, 32'ha0);
    wr(`PK OFF_THRESHOLD, 32'h0);
    wr(`PK OFF_VTBASE, 32'h1234_5fff);
    vtb = 32'h1234_5c00;
    rd("vtbase", `PK OFF_VTBASE, vtb);
    for (int g = 0; g < 8; g++) begin
      wr(`PK OFF_GROUPING, 32'(g));
      rd("grouping", `PK OFF_GROUPING, 32'(g));
    end
    wr(`PK OFF_ACTIVE, 32'h1, `PK AXI_SLVERR);
    rd("unmapped", 8'h30, 32'h0, `PK AXI_SLVERR);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_prio(input logic [31:0] g);
    wr(`PK OFF_GROUPING, g);
    setp(2, 8'h60);
    setp(9, 8'h5f);
    setp(12, 8'h40);
    rd("prio", `PK OFF_PRIO_BASE + 8'h24, 32'h5f);
    wr(`PK OFF_PEND_SET, 32'h1204);
    took(4'd9);
    quiet(10);
    u_core.finish();
    took(4'd12);
    u_core.finish();
    took(4'd2);
    wr(`PK OFF_PEND_SET, 32'h20);
    took(4'd5);
    u_core.finish();
    u_core.finish();
    $display("t_prio done");
  endtask : t_prio
  task automatic t_mask();
    setp(6, 8'h80);
    setp(7, 8'h60);
    wr(`PK OFF_THRESHOLD, 32'h80);
    wr(`PK OFF_PEND_SET, 32'h40);
    quiet(10);
    wr(`PK OFF_PEND_SET, 32'h80);
    took(4'd7);
    u_core.finish();
    wr(`PK OFF_THRESHOLD, 32'h0);
    took(4'd6);
    u_core.finish();
    $display("t_mask done");
  endtask : t_mask
  task automatic t_clr();
    wr(`PK OFF_ENABLE, 32'hfbff);
    @(posedge clk);
    src[10] <= 1'b1;
    quiet(8);
    rd("pending", `PK OFF_PEND_SET, 32'h400);
    wr(`PK OFF_PEND_CLR, 32'h400);
    rd("cleared", `PK OFF_PEND_CLR, 32'h0);
    wr(`PK OFF_ENABLE, 32'hffff);
    quiet(10);
    src[10] <= 1'b0;
    rd("events", `PK OFF_EVT_STAT, 32'h3);
    `CHK("evt masked", 1'b0, evt)
    wr(`PK OFF_EVT_MASK, 32'h2);
    repeat (2) @(posedge clk);
    `CHK("evt raised", 1'b1, evt)
    wr(`PK OFF_EVT_STAT, 32'h3);
    repeat (2) @(posedge clk);
    `CHK("evt cleared", 1'b0, evt)
    $display("t_clr done");
  endtask : t_clr
  task automatic t_gate();
    wr(`PK OFF_GATE, 32'h0);
    @(posedge clk);
    src[0] <= 1'b1;
    quiet(10);
    rd("enable kept", `PK OFF_ENABLE, 32'hffff);
    wr(`PK OFF_VTBASE, 32'h2000_0400);
    vtb = 32'h2000_0400;
    wr(`PK OFF_GATE, 32'h1);
    took(4'd0);
    u_core.finish();
    src[0] <= 1'b0;
    $display("t_gate done");
  endtask : t_gate
  task automatic stop_test();
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : stop_test
  // hang guard
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      stop_test();
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    t_regs();
    wr(`PK OFF_ENABLE, 32'hffff);
    wr(`PK OFF_GATE, 32'h1);
    t_prio(32'h3);
    t_prio(32'h7);
    t_mask();
    t_clr();
    t_gate();
    stop_test();
  end
endmodule : tb
`default_nettype wire
